// >>> pkg/relay_seq_consts.vh
// Constants for the relay switch sequencer: register map, fields, resets and timing.
`ifndef RELAY_SEQ_CONSTS_VH
`define RELAY_SEQ_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define RSS_OFF_CTRL 12'h000
`define RSS_OFF_EXTRA 12'h004
`define RSS_OFF_ROWS 12'h008
`define RSS_OFF_SETUP_IDX 12'h00c
`define RSS_OFF_SETUP_DATA 12'h010
`define RSS_OFF_STATUS 12'h014
`define RSS_OFF_HW_SETTLE 12'h018

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define RSS_CTRL_ENABLE 0
`define RSS_CTRL_SRC_LO 1
`define RSS_CTRL_EXT_RISE 4
`define RSS_CTRL_READY_HIGH 5
`define RSS_ROW_TOG_MB 8
`define RSS_ROW_TOG_BM 9
`define RSS_ROW_COLUMN 10
`define RSS_ST_READY 0
`define RSS_ST_SETTLED 1
`define RSS_ST_UNSETTLED 2
`define RSS_ST_OVERRUN 3
`define RSS_ST_BAD_ROW 4
`define RSS_ST_STEP_LO 8

// ----------------------------------------------------------------------------
// Trigger source codes and reset values
// ----------------------------------------------------------------------------
`define RSS_SRC_TALK 3'h0
`define RSS_SRC_GET 3'h1
`define RSS_SRC_EXEC 3'h2
`define RSS_SRC_EXT 3'h3
`define RSS_SRC_KEY 3'h4
`define RSS_EXTRA_RESET 16'h0000
`define RSS_EXTRA_MAX 32'd65000
`define RSS_STEP_LAST 7'd100
`define RSS_COLS 4

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RSS_CLK_NS 10
`define RSS_MS_NS 1000000
`define RSS_XFER_NS 1000

`endif

// >>> hdl/pin_edge_sync.v
// Two-stage synchroniser for an outside pin with rising and falling edge pulses.
`timescale 1ns/1ps
module pin_edge_sync
(
  // Clock and reset
  input wire i_clock,
  input wire i_rst_b,
  // Pin and edges
  input wire i_pin,
  output wire o_rise,
  output wire o_fall
);
  reg meta;
  reg sync;
  reg last;

  // ----------------------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------------------
  // The first stage feeds only the second; edges are taken from later stages.
  always @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end
    else
    begin
      meta <= i_pin;
      sync <= meta;
      last <= sync;
    end
  end

  assign o_rise = sync & ~last;
  assign o_fall = ~sync & last;
endmodule // pin_edge_sync

// >>> hdl/ms_delay_timer.v
// Millisecond delay timer: counts a loaded number of milliseconds, then pulses done.
`timescale 1ns/1ps
module ms_delay_timer
#(
  parameter CYCLES_PER_MS = 100000
)
(
  // Clock and reset
  input wire i_clock,
  input wire i_rst_b,
  // Control
  input wire i_start,
  input wire [16:0] i_ms,
  output wire o_busy,
  output wire o_done
);
  reg busy;
  reg done;
  reg [16:0] ms_left;
  reg [31:0] prescale;

  // ----------------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------------
  // A new start reloads the count, so a restarted change times from scratch.
  always @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      ms_left <= 17'h00000;
      prescale <= 32'h00000000;
    end
    else
    begin
      done <= 1'b0;
      if (i_start)
      begin
        busy <= 1'b1;
        ms_left <= i_ms;
        prescale <= 32'h00000000;
      end
      else if (busy)
      begin
        if (ms_left == 17'h00000)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else if (prescale == CYCLES_PER_MS - 1)
        begin
          prescale <= 32'h00000000;
          ms_left <= ms_left - 17'h00001;
        end
        else
        begin
          prescale <= prescale + 32'h00000001;
        end
      end
    end
  end

  assign o_busy = busy;
  assign o_done = done;
endmodule // ms_delay_timer

// >>> hdl/relay_switch_sequencer.v
// Relay switch sequencer: trigger handling, row-mode stepping, settling and APB registers.
//
// Behaviour
// R1: Extra settling delay in millisecond steps.
// R2: Accept extra delay 0..65000 ms only.
// R3: Extra delay applies to every relay change; code adds it after the final setup of a trigger only.
// R4: Settle-done asserts when extra delay expires.
// R5: Trigger during settling processed, unsettled flag set.
// R6: Each row holds one of three modes.
// R7: Row never both modes; deselect gives don't-care.
// R8: Bad row toggle request rejected and flagged.
// R9: Make-before-break only: close, then open.
// R10: Break-before-make only: open, then close.
// R11: Both types: three intermediate setups in order.
// R12: No special rows: apply target directly.
// R13: One relay settle per intermediate setup.
// R14: Trigger sends setup pointer plus one, advances.
// R15: Enable key toggles enable; lamp shows it.
// R16: Five sources; external pulse after reset.
// R17: Manual key works unless in remote.
// R18: Key-only source ignores all other sources.
// R19: No triggers once pointer reaches 100.
// R20: Trigger during transfer dropped, overrun flagged.
// R21: Ready again once transfer time elapses.
// R22: Ready and settled bits in status byte.
// R23: Row modes broadcast to all chained units.
// R24: Settle-done polarity selectable, leading edge marks end.
// R25: External trigger edge selectable rising or falling.
// R26: Relay settle is longest card settle reported.
// R27: Disabled triggers ignored, pointer unchanged.
// R28: Timers start after final transfer; done held low.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "relay_seq_consts.vh"
module relay_switch_sequencer
#(
  parameter CYCLES_PER_MS = `RSS_MS_NS / `RSS_CLK_NS,
  parameter [15:0] XFER_CYCLES = `RSS_XFER_NS / `RSS_CLK_NS
)
(
  // Clock and reset
  input wire i_clock,
  input wire i_rst_b,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  // Trigger pins and bus command pulses
  input wire i_ext_trigger,
  input wire i_manual_key,
  input wire i_enable_key,
  input wire i_bus_talk,
  input wire i_bus_get,
  input wire i_bus_exec,
  input wire i_remote,
  // Card identification
  input wire i_card_settle_valid,
  input wire [15:0] i_card_settle_ms,
  // Relay cards
  output wire [31:0] o_relay_data,
  output wire o_relay_load,
  // Indicators and chain
  output wire o_trigger_ready,
  output wire o_matrix_ready,
  output wire o_enable_lamp,
  output wire o_bad_row_entry,
  output wire o_unsettled_trigger_flag,
  output wire o_trigger_overrun_flag,
  output wire [7:0] o_row_make_break,
  output wire [7:0] o_row_break_make
);
  localparam ST_IDLE = 2'd0;
  localparam ST_XFER = 2'd1;
  localparam ST_STEP_SETTLE = 2'd2;
  localparam ST_FINAL_SETTLE = 2'd3;
  localparam PH_FINAL = 2'd3;

  // ----------------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------------
  function [31:0] row_expand;
    input [7:0] rows;
    integer i;
    begin
      row_expand = 32'h00000000;
      for (i = 0; i < 8; i = i + 1)
        row_expand[i*`RSS_COLS +: `RSS_COLS] = {`RSS_COLS{rows[i]}};
    end
  endfunction

  // First enabled phase at or after a start point; the final phase is always enabled.
  function [1:0] pick_phase;
    input [2:0] from;
    input any_mb;
    input any_bm;
    begin
      if (from == 3'd0 && any_bm)
        pick_phase = 2'd0;
      else if (from <= 3'd1 && any_mb)
        pick_phase = 2'd1;
      else if (from <= 3'd2 && any_mb && any_bm)
        pick_phase = 2'd2;
      else
        pick_phase = PH_FINAL;
    end
  endfunction

  function [31:0] compose;
    input [1:0] ph;
    input [31:0] orig;
    input [31:0] tgt;
    input [31:0] mmask;
    input [31:0] bmask;
    reg [31:0] s_a;
    reg [31:0] s_b;
    reg [31:0] s_c;
    begin
      s_a = (orig & ~bmask) | (orig & tgt & bmask);
      s_b = s_a | (tgt & mmask);
      s_c = (s_b & ~mmask) | (tgt & mmask);
      case (ph)
        2'd0: compose = s_a;
        2'd1: compose = s_b;
        2'd2: compose = s_c;
        default: compose = tgt;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  reg trig_enable;
  reg [2:0] source;
  reg ext_rise;
  reg ready_high;
  reg [15:0] extra_delay_value;
  reg [7:0] row_mb;
  reg [7:0] row_bm;
  reg [6:0] setup_idx;
  reg [31:0] setup_mem [0:99];
  reg [15:0] hw_settle;
  reg unsettled_trigger_flag;
  reg trigger_overrun_flag;
  reg bad_row_flag;
  reg settle_done;
  reg [1:0] state;
  reg [1:0] phase;
  reg [15:0] xfer_cnt;
  reg [6:0] step_ptr;
  reg [31:0] relays;
  reg [31:0] orig;
  reg [31:0] target;
  reg [31:0] mb_mask;
  reg [31:0] bm_mask;
  reg [31:0] prdata;
  reg pslverr;
  reg [31:0] rd_mux;
  reg rd_err;
  wire [2:0] pin_rise;
  wire [2:0] pin_fall;
  wire [2:0] pins;
  wire wr;
  wire ext_edge;
  wire stimulus;
  wire trig;
  wire xfer_end;
  wire timer_done;
  wire [16:0] timer_ms;
  wire [7:0] row_sel;
  wire row_ok;
  wire [31:0] new_target;
  wire [1:0] first_phase;
  wire [1:0] next_phase;

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  assign pins = {i_enable_key, i_manual_key, i_ext_trigger};

  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_pin
      pin_edge_sync u_sync
      (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .i_pin(pins[g]),
        .o_rise(pin_rise[g]),
        .o_fall(pin_fall[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Trigger qualification
  // ----------------------------------------------------------------------------
  assign ext_edge = ext_rise ? pin_rise[0] : pin_fall[0]; // [R25]
  assign stimulus = (pin_rise[1] & ~i_remote) | // [R17]
    ((source == `RSS_SRC_EXT) & ext_edge) | // [R18]
    ((source == `RSS_SRC_TALK) & i_bus_talk) |
    ((source == `RSS_SRC_GET) & i_bus_get) |
    ((source == `RSS_SRC_EXEC) & i_bus_exec); // [R16]
  // Disabled triggers and an exhausted pointer leave everything untouched.
  assign trig = stimulus & trig_enable & (step_ptr < `RSS_STEP_LAST); // [R27] [R19]

  // ----------------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------------
  assign new_target = setup_mem[step_ptr]; // [R14]
  assign first_phase = pick_phase(3'd0, |row_mb, |row_bm); // [R12]
  assign next_phase = pick_phase({1'b0, phase} + 3'd1, |mb_mask, |bm_mask);
  assign xfer_end = (state == ST_XFER) && (xfer_cnt == XFER_CYCLES - 16'd1);
  // Intermediate steps wait one relay settle; the last adds the extra delay.
  assign timer_ms = (phase == PH_FINAL) ?
    ({1'b0, hw_settle} + {1'b0, extra_delay_value}) : {1'b0, hw_settle}; // [R1] [R3] [R13]

  ms_delay_timer #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_timer
  (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_start(xfer_end), // [R28]
    .i_ms(timer_ms),
    .o_busy(),
    .o_done(timer_done)
  );

  always @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      state <= ST_IDLE;
      phase <= PH_FINAL;
      xfer_cnt <= 16'h0000;
      step_ptr <= 7'h00;
      relays <= 32'h00000000;
      orig <= 32'h00000000;
      target <= 32'h00000000;
      mb_mask <= 32'h00000000;
      bm_mask <= 32'h00000000;
      settle_done <= 1'b1;
    end
    else if (trig && (state == ST_IDLE || state == ST_FINAL_SETTLE)) // [R21]
    begin
      state <= ST_XFER;
      phase <= first_phase;
      xfer_cnt <= 16'h0000;
      step_ptr <= step_ptr + 7'd1; // [R14]
      orig <= relays;
      target <= new_target;
      mb_mask <= row_expand(row_mb);
      bm_mask <= row_expand(row_bm);
      relays <= compose(first_phase, relays, new_target,
        row_expand(row_mb), row_expand(row_bm)); // [R9] [R10] [R11]
      settle_done <= 1'b0; // [R28]
    end
    else
    begin
      case (state)
        ST_XFER:
        begin
          xfer_cnt <= xfer_cnt + 16'd1;
          if (xfer_end)
            state <= (phase == PH_FINAL) ? ST_FINAL_SETTLE : ST_STEP_SETTLE;
        end
        ST_STEP_SETTLE:
        begin
          if (timer_done)
          begin
            state <= ST_XFER;
            xfer_cnt <= 16'h0000;
            phase <= next_phase;
            relays <= compose(next_phase, orig, target, mb_mask, bm_mask); // [R11] [R13]
          end
        end
        ST_FINAL_SETTLE:
        begin
          if (timer_done)
          begin
            state <= ST_IDLE;
            settle_done <= 1'b1; // [R4]
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // APB access
  // ----------------------------------------------------------------------------
  assign wr = i_psel & i_penable & i_pwrite & ~pslverr;
  assign row_sel = i_pwdata[7:0];
  // A lone row with exactly one mode key and no column address is accepted.
  assign row_ok = (row_sel != 8'h00) && ((row_sel & (row_sel - 8'h01)) == 8'h00) &&
    !i_pwdata[`RSS_ROW_COLUMN] &&
    (i_pwdata[`RSS_ROW_TOG_MB] ^ i_pwdata[`RSS_ROW_TOG_BM]); // [R8]

  always @*
  begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    case (i_paddr)
      `RSS_OFF_CTRL:
      begin
        rd_mux = {26'h0000000, ready_high, ext_rise, source, trig_enable};
        rd_err = i_pwrite && (i_pwdata[`RSS_CTRL_SRC_LO +: 3] > `RSS_SRC_KEY);
      end
      `RSS_OFF_EXTRA:
      begin
        rd_mux = {16'h0000, extra_delay_value};
        rd_err = i_pwrite && (i_pwdata > `RSS_EXTRA_MAX); // [R2]
      end
      `RSS_OFF_ROWS:
        rd_mux = {16'h0000, row_bm, row_mb};
      `RSS_OFF_SETUP_IDX:
      begin
        rd_mux = {25'h0000000, setup_idx};
        rd_err = i_pwrite && ((i_pwdata == 32'h00000000) || (i_pwdata > 32'd100));
      end
      `RSS_OFF_SETUP_DATA:
        rd_mux = setup_mem[setup_idx - 7'd1];
      `RSS_OFF_STATUS:
        rd_mux = {17'h00000, step_ptr, 3'h0, bad_row_flag, trigger_overrun_flag,
          unsettled_trigger_flag, settle_done, o_trigger_ready}; // [R22]
      `RSS_OFF_HW_SETTLE:
      begin
        rd_mux = {16'h0000, hw_settle};
        rd_err = i_pwrite;
      end
      default:
        rd_err = 1'b1;
    endcase
  end

  // Read data and the error answer are caught in the setup cycle, so the
  // access cycle can complete at once with no wait state.
  always @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (i_psel && !i_penable)
    begin
      prdata <= i_pwrite ? 32'h00000000 : rd_mux;
      pslverr <= rd_err;
    end
  end

  // ----------------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------------
  always @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      trig_enable <= 1'b0;
      source <= `RSS_SRC_EXT; // [R16]
      ext_rise <= 1'b0;
      ready_high <= 1'b1;
      extra_delay_value <= `RSS_EXTRA_RESET;
      row_mb <= 8'h00;
      row_bm <= 8'h00;
      setup_idx <= 7'd1;
      hw_settle <= 16'h0000;
    end
    else
    begin
      if (pin_rise[2])
        trig_enable <= ~trig_enable; // [R15]
      else if (wr && i_paddr == `RSS_OFF_CTRL)
        trig_enable <= i_pwdata[`RSS_CTRL_ENABLE];
      if (wr && i_paddr == `RSS_OFF_CTRL)
      begin
        source <= i_pwdata[`RSS_CTRL_SRC_LO +: 3];
        ext_rise <= i_pwdata[`RSS_CTRL_EXT_RISE];
        ready_high <= i_pwdata[`RSS_CTRL_READY_HIGH];
      end
      // A rejected value never reaches here, so the old delay stays.
      if (wr && i_paddr == `RSS_OFF_EXTRA)
        extra_delay_value <= i_pwdata[15:0]; // [R2]
      if (wr && i_paddr == `RSS_OFF_ROWS && row_ok)
      begin
        if (i_pwdata[`RSS_ROW_TOG_MB])
        begin
          row_mb <= row_mb ^ row_sel; // [R6]
          row_bm <= row_bm & ~row_sel; // [R7]
        end
        else
        begin
          row_bm <= row_bm ^ row_sel; // [R6]
          row_mb <= row_mb & ~row_sel; // [R7]
        end
      end
      if (wr && i_paddr == `RSS_OFF_SETUP_IDX)
        setup_idx <= i_pwdata[6:0];
      if (i_card_settle_valid && i_card_settle_ms > hw_settle)
        hw_settle <= i_card_settle_ms; // [R26]
    end
  end

  always @(posedge i_clock)
  begin
    if (wr && i_paddr == `RSS_OFF_SETUP_DATA)
      setup_mem[setup_idx - 7'd1] <= i_pwdata;
  end

  // ----------------------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------------------
  // Writing one clears a flag, but an event in the same cycle keeps it set.
  always @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      unsettled_trigger_flag <= 1'b0;
      trigger_overrun_flag <= 1'b0;
      bad_row_flag <= 1'b0;
    end
    else
    begin
      unsettled_trigger_flag <= (trig && state == ST_FINAL_SETTLE) | // [R5]
        (unsettled_trigger_flag &
        ~(wr && i_paddr == `RSS_OFF_STATUS && i_pwdata[`RSS_ST_UNSETTLED]));
      trigger_overrun_flag <= (trig && (state == ST_XFER || state == ST_STEP_SETTLE)) | // [R20]
        (trigger_overrun_flag &
        ~(wr && i_paddr == `RSS_OFF_STATUS && i_pwdata[`RSS_ST_OVERRUN]));
      bad_row_flag <= (wr && i_paddr == `RSS_OFF_ROWS && !row_ok) | // [R8]
        (bad_row_flag &
        ~(wr && i_paddr == `RSS_OFF_STATUS && i_pwdata[`RSS_ST_BAD_ROW]));
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign o_prdata = prdata;
  assign o_pready = i_psel & i_penable;
  assign o_pslverr = i_psel & i_penable & pslverr;
  assign o_relay_data = relays;
  assign o_relay_load = (state == ST_XFER);
  assign o_trigger_ready = (state == ST_IDLE) || (state == ST_FINAL_SETTLE); // [R21]
  assign o_matrix_ready = ready_high ? settle_done : ~settle_done; // [R24]
  assign o_enable_lamp = trig_enable; // [R15]
  assign o_bad_row_entry = bad_row_flag;
  assign o_unsettled_trigger_flag = unsettled_trigger_flag;
  assign o_trigger_overrun_flag = trigger_overrun_flag;
  // Chained units take their row modes from these lines.
  assign o_row_make_break = row_mb; // [R23]
  assign o_row_break_make = row_bm; // [R23]
endmodule // relay_switch_sequencer

// >>> dv/relay_seq_checker_sva.sv
// Checker for the relay switch sequencer ports.
`timescale 1ns/1ps
module relay_seq_checker
(
  // Clock and reset
  input logic i_clock,
  input logic i_rst_b,
  // Watched outputs
  input logic o_relay_load,
  input logic o_trigger_ready,
  input logic o_matrix_ready,
  input logic o_unsettled_trigger_flag,
  input logic o_trigger_overrun_flag,
  input logic [7:0] o_row_make_break,
  input logic [7:0] o_row_break_make
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  // ------------------------------
  // Properties
  // ------------------------------
  property p_load_len;
    $rose(o_relay_load) |-> o_relay_load [*4] ##1 !o_relay_load;
  endproperty
  a_load_len: assert property (p_load_len) else $error("transfer length wrong");
  property p_accept;
    $fell(o_trigger_ready) |-> $rose(o_relay_load);
  endproperty
  a_accept: assert property (p_accept) else $error("ready fell without transfer");
  property p_busy;
    o_relay_load |-> !o_trigger_ready && !o_matrix_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready during transfer");
  property p_overrun;
    $rose(o_trigger_overrun_flag) |-> $past(!o_trigger_ready);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun while ready");
  property p_unsettled;
    $rose(o_unsettled_trigger_flag) |->
      $past(o_trigger_ready && !o_matrix_ready) && o_relay_load;
  endproperty
  a_unsettled: assert property (p_unsettled) else $error("unsettled flag wrong");
  property p_ready_rise;
    $rose(o_trigger_ready) |-> $fell(o_relay_load);
  endproperty
  a_ready_rise: assert property (p_ready_rise) else $error("ready rose early");
  property p_hold;
    $fell(o_relay_load) && o_trigger_ready |-> !o_matrix_ready [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("settled too soon");
  property p_settle_rise;
    $rose(o_matrix_ready) |-> o_trigger_ready && !o_relay_load;
  endproperty
  a_settle_rise: assert property (p_settle_rise) else $error("settled mid sequence");
  property p_rows;
    (o_row_make_break & o_row_break_make) == 8'h00;
  endproperty
  a_rows: assert property (p_rows) else $error("row in both modes");
endmodule // relay_seq_checker

bind relay_switch_sequencer relay_seq_checker u_relay_seq_checker (.*);

// >>> dv/relay_card_model.sv
// Relay card model: reports card settle times and logs each setup it receives.
`timescale 1ns/1ps
module relay_card_model
(
  // Clock and reset
  input logic i_clock,
  input logic i_rst_b,
  // Relay bus
  input logic [31:0] i_relay_data,
  input logic i_relay_load,
  // Card report and load count
  output logic o_card_settle_valid,
  output logic [15:0] o_card_settle_ms,
  output logic [7:0] o_loads
);
  logic [31:0] log_q [0:7];
  logic [1:0] rep;
  logic load_q;
  always @(posedge i_clock)
  begin
    load_q <= i_relay_load;
    o_card_settle_valid <= 1'b0;
    // Outside a report the value is scrambled so a stale latch shows.
    o_card_settle_ms <= ~o_card_settle_ms;
    if (!i_rst_b)
    begin
      rep <= 2'h0;
      o_loads <= 8'h00;
    end
    else
    begin
      if (rep != 2'h2)
      begin
        rep <= rep + 2'h1;
        o_card_settle_valid <= 1'b1;
        o_card_settle_ms <= (rep == 2'h0) ? 16'h0002 : 16'h0001;
      end
      if (i_relay_load && !load_q)
      begin
        log_q[o_loads[2:0]] <= i_relay_data;
        o_loads <= o_loads + 8'h01;
      end
    end
  end
endmodule // relay_card_model

// >>> dv/tb_top.sv
// Testbench for the relay switch sequencer.
`timescale 1ns/1ps
`include "relay_seq_consts.vh"
module tb_top;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic i_ext_trigger = 1'b1, i_manual_key = 1'b0, i_enable_key = 1'b0;
  logic i_bus_talk = 1'b0, i_bus_get = 1'b0, i_bus_exec = 1'b0, i_remote = 1'b0;
  wire [31:0] o_prdata, o_relay_data;
  wire o_pready, o_pslverr, o_relay_load, o_trigger_ready, o_matrix_ready;
  wire o_enable_lamp, o_bad_row_entry, o_unsettled_trigger_flag, o_trigger_overrun_flag;
  wire i_card_settle_valid;
  wire [15:0] i_card_settle_ms;
  wire [7:0] o_row_make_break, o_row_break_make, loads;
  int miscompares = 0, n_compared = 0, n;
  logic [31:0] rd;
  logic err;
  logic [7:0] l0;
  logic [31:0] both_exp [4] = '{32'h01111111, 32'h01111113, 32'h01111112, 32'h22222222};
  relay_switch_sequencer #(.CYCLES_PER_MS(10), .XFER_CYCLES(16'd4)) u_relay_switch_sequencer
    (.*);
  relay_card_model u_relay_card_model
  (
    .i_clock, .i_rst_b, .i_relay_data(o_relay_data), .i_relay_load(o_relay_load),
    .o_card_settle_valid(i_card_settle_valid), .o_card_settle_ms(i_card_settle_ms),
    .o_loads(loads)
  );
  initial forever #5 i_clock = ~i_clock;
  // ------------------------------
  // Tasks
  // ------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    n = 0;
    do @(posedge i_clock); while (o_pready !== 1'b1 && n++ < 20);
    if (n > 20)
      miscompares++;
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    #1;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task fire(input int k);
    @(posedge i_clock);
    case (k)
      0: i_bus_talk <= 1'b1;
      1: i_bus_get <= 1'b1;
      2: i_bus_exec <= 1'b1;
      3: i_ext_trigger <= !i_ext_trigger;
      4: i_manual_key <= 1'b1;
      default: i_enable_key <= 1'b1;
    endcase
    @(posedge i_clock);
    {i_bus_talk, i_bus_get, i_bus_exec} <= 3'h0;
    if (k > 2)
      repeat (5) @(posedge i_clock);
    {i_manual_key, i_enable_key} <= 2'h0;
    #1;
  endtask
  task wait_low();
    n = 0;
    while (o_relay_load !== 1'b0 && n++ < 50)
      @(posedge i_clock);
    if (n > 50)
      miscompares++;
  endtask
  task trig(input int k, input int exp);
    l0 = loads;
    fire(k);
    n = 0;
    while (!(o_trigger_ready === 1'b1 && o_matrix_ready === 1'b1) && n++ < 400)
      @(posedge i_clock);
    if (n > 400)
      miscompares++;
    chk({24'h0, loads - l0}, exp);
  endtask
  task complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #300000;
    miscompares++;
    complete_run();
  end
  // ------------------------------
  // Tests
  // ------------------------------
  initial
  begin
    repeat (12) @(posedge i_clock);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_clock);
    rdc(`RSS_OFF_CTRL, 32'h26);
    rdc(`RSS_OFF_STATUS, 32'h3);
    rdc(`RSS_OFF_HW_SETTLE, 32'h2);
    $display("Test reset values done");
    wr(`RSS_OFF_EXTRA, 32'd65000);
    rdc(`RSS_OFF_EXTRA, 32'd65000);
    wr(`RSS_OFF_EXTRA, 32'd65001);
    chk(err, 1'b1);
    rdc(`RSS_OFF_EXTRA, 32'd65000);
    wr(`RSS_OFF_EXTRA, 32'd1);
    $display("Test extra delay done");
    wr(`RSS_OFF_ROWS, 32'h101);
    rdc(`RSS_OFF_ROWS, 32'h1);
    wr(`RSS_OFF_ROWS, 32'h201);
    rdc(`RSS_OFF_ROWS, 32'h100);
    wr(`RSS_OFF_ROWS, 32'h201);
    rdc(`RSS_OFF_ROWS, 32'h0);
    wr(`RSS_OFF_ROWS, 32'h103);
    chk(o_bad_row_entry, 1'b1);
    wr(`RSS_OFF_STATUS, 32'h10);
    wr(`RSS_OFF_ROWS, 32'h501);
    chk(o_bad_row_entry, 1'b1);
    rdc(`RSS_OFF_ROWS, 32'h0);
    wr(`RSS_OFF_STATUS, 32'h10);
    $display("Test row modes done");
    // Odd and even setups differ.
    for (int i = 1; i <= 100; i++)
    begin
      wr(`RSS_OFF_SETUP_IDX, i);
      wr(`RSS_OFF_SETUP_DATA, i[0] ? 32'h11111111 : 32'h22222222);
    end
    for (int s = 0; s < 5; s++)
    begin
      wr(`RSS_OFF_CTRL, 32'h21 | (s << 1));
      trig(s, 1);
    end
    $display("Test sources done");
    wr(`RSS_OFF_CTRL, 32'h25);
    fire(2);
    chk(o_relay_data, 32'h22222222);
    wait_low();
    n = 0;
    while (o_matrix_ready !== 1'b1 && n < 100)
    begin
      @(posedge i_clock);
      n++;
    end
    chk(n >= 29 && n <= 35, 1'b1);
    fire(2);
    fire(2);
    chk(o_trigger_overrun_flag, 1'b1);
    wait_low();
    trig(2, 1);
    chk(o_unsettled_trigger_flag, 1'b1);
    rdc(`RSS_OFF_STATUS, 32'h80f);
    wr(`RSS_OFF_STATUS, 32'h1c);
    $display("Test timing and overrun done");
    for (int c = 0; c < 3; c++)
    begin
      wr(`RSS_OFF_ROWS, c == 1 ? 32'h280 : 32'h101);
      trig(2, c == 1 ? 4 : 2);
      if (c == 1)
        for (int i = 0; i < 4; i++)
          chk(u_relay_card_model.log_q[3'(l0 + i)], both_exp[i]);
    end
    wr(`RSS_OFF_ROWS, 32'h280);
    $display("Test sequencing done");
    wr(`RSS_OFF_CTRL, 32'h24);
    trig(2, 0);
    fire(5);
    chk(o_enable_lamp, 1'b1);
    trig(2, 1);
    wr(`RSS_OFF_CTRL, 32'h29);
    trig(2, 0);
    trig(3, 0);
    i_remote <= 1'b1;
    trig(4, 0);
    i_remote <= 1'b0;
    trig(4, 1);
    wr(`RSS_OFF_CTRL, 32'h37);
    trig(3, 0);
    trig(3, 1);
    $display("Test enable and sources done");
    wr(`RSS_OFF_CTRL, 32'h25);
    for (int i = 14; i < 100; i++)
      trig(2, 1);
    trig(2, 0);
    rdc(`RSS_OFF_STATUS, 32'h6403);
    wr(`RSS_OFF_CTRL, 32'h05);
    chk(o_matrix_ready, 1'b0);
    $display("Test step limit and polarity done");
    complete_run();
  end
endmodule // tb_top
